/* File: rtl/matchfifo.sv */
// bus-matching fifo with reset-latched modes, flags and axi4-lite status
`timescale 1ns/1ps
`include "matchfifo_defs.svh"
module matchfifo
    import matchfifo_pkg::*;
(
    // clock and reset
    input  wire logic               clock_i,
    input  wire logic               rst_i,
    input  wire logic               master_reset_n_i,
    // reset-sampled configuration
    input  wire logic               byte_order_select_i,
    input  wire logic               write_width_select_i,
    input  wire logic               read_width_select_i,
    input  wire logic               parity_placement_select_i,
    input  wire logic               offset_default_sel0_i,
    input  wire logic               offset_default_sel1_i,
    input  wire logic               fall_through_mode_i,
    input  wire logic               offset_access_enable_n_i,
    // write and read ports
    input  wire logic [17:0]        write_data_in_i,
    input  wire logic               write_en_n_i,
    input  wire logic               serial_en_n_i,
    input  wire logic               read_en_n_i,
    output logic      [17:0]        read_data_o,
    // flags
    output logic                    empty_flag_n_o,
    output logic                    full_indicator_n_o,
    output logic                    half_level_flag_n_o,
    output logic                    almost_empty_flag_n_o,
    output logic                    almost_full_flag_n_o,
    output logic                    irq_o,
    // axi4-lite slave
    input  wire logic [3:0]         s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic      [1:0]         s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [3:0]         s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic      [31:0]        s_axi_rdata,
    output logic      [1:0]         s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready
);
    cfg_t                 cfg_q;
    logic [`MF_AW-1:0]    wr_ptr_q, rd_ptr_q, rd_ptr_d;
    logic [`MF_CW-1:0]    cnt_q, cnt_d;
    logic                 whalf_q, rhalf_q, rhalf_d, lsel_q, rsel_q;
    logic [8:0]           wbyte_q;
    logic [`MF_OFFW-1:0]  empty_off_q, full_off_q;
    logic [`MF_DW-1:0]    head, push_word;
    logic [17:0]          data_q;
    logic [`MF_EVW-1:0]   stat_q, mask_q, ev;
    logic                 ef_q, ff_q, hf_q, pae_q, paf_q, irq_q;

    // pick the default offset from the three reset-time select pins
    function automatic logic [`MF_OFFW-1:0] def_off(input logic [2:0] s);
        case (s)
            3'h0: def_off = `MF_DEF0;
            3'h1: def_off = `MF_DEF1;
            3'h2: def_off = `MF_DEF2;
            3'h3: def_off = `MF_DEF3;
            3'h4: def_off = `MF_DEF4;
            3'h5: def_off = `MF_DEF5;
            3'h6: def_off = `MF_DEF6;
            default: def_off = `MF_DEF7;
        endcase
    endfunction

    // byte of a stored word in read order
    function automatic logic [8:0] pick(input logic [17:0] w, input logic le,
                                        input logic second);
        pick = (le ^ second) ? w[8:0] : w[17:9];
    endfunction

    // decode of port requests; the access pin steers them to the offsets
    wire master_reset      = !master_reset_n_i;
    wire acc      = !offset_access_enable_n_i;
    wire wr_req   = !write_en_n_i && !acc && !master_reset;
    wire rd_req   = !read_en_n_i && !acc && !master_reset;
    wire pload    = !write_en_n_i && acc && !master_reset && !cfg_q.serial;
    wire sload    = !serial_en_n_i && acc && !master_reset && cfg_q.serial;
    wire oread    = !read_en_n_i && acc && !master_reset;
    wire can_wr   = cnt_q != `MF_DEPTH;
    wire can_rd   = cnt_q != `MF_CW'(0);
    wire wr_ok    = wr_req && can_wr;
    wire rd_ok    = rd_req && can_rd;
    wire push     = wr_ok && (!cfg_q.wr_x9 || whalf_q);
    wire pop      = rd_ok && (!cfg_q.rd_x9 || rhalf_q);
    wire [8:0] lo9 = write_data_in_i[8:0];
    // the parity pin plays no part in the data path below
    assign push_word = !cfg_q.wr_x9 ? write_data_in_i :
                       cfg_q.little_end ? {lo9, wbyte_q} : {wbyte_q, lo9};
    // parallel offset value; bit 8 is parity only for interspersed x18
    wire [`MF_OFFW-1:0] pval =
        cfg_q.wr_x9 ? {8'h00, lo9} :
        cfg_q.ip    ? {1'b0, write_data_in_i[16:9], write_data_in_i[7:0]} :
                      {1'b0, write_data_in_i[15:0]};
    assign cnt_d    = cnt_q + `MF_CW'(push) - `MF_CW'(pop);
    assign rd_ptr_d = rd_ptr_q + `MF_AW'(pop);
    assign rhalf_d  = cfg_q.rd_x9 && rd_ok ? !rhalf_q : rhalf_q;
    // fall-through looks at the head after this cycle, standard at the current one
    wire [`MF_AW-1:0] raddr = cfg_q.fall_through_mode ? rd_ptr_d : rd_ptr_q;
    wire              rsec  = cfg_q.fall_through_mode ? rhalf_d : rhalf_q;
    wire [17:0] view = cfg_q.rd_x9 ? {9'h000, pick(head, cfg_q.little_end, rsec)} : head;
    wire [`MF_CW-1:0] free_d = `MF_DEPTH - cnt_d;

    matchfifo_store u_store (
        .clock_i (clock_i),
        .we_i    (push),
        .waddr_i (wr_ptr_q),
        .wdata_i (push_word),
        .raddr_i (raddr),
        .rdata_o (head)
    );

    // mode latches follow the pins during master reset and hold after release
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cfg_q <= '0;
        end else if (master_reset) begin
            cfg_q <= '{little_end: byte_order_select_i,
                       wr_x9:      write_width_select_i,
                       rd_x9:      read_width_select_i,
                       ip:         parity_placement_select_i,
                       fall_through_mode:       fall_through_mode_i,
                       serial:     offset_access_enable_n_i,
                       fsel:       {offset_default_sel1_i, offset_default_sel0_i}};
        end
    end

    // pointers, byte pairing and count
    always_ff @(posedge clock_i) begin
        if (rst_i || master_reset) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
            whalf_q  <= 1'b0;
            rhalf_q  <= 1'b0;
            wbyte_q  <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_q + `MF_AW'(push);
            rd_ptr_q <= rd_ptr_d;
            cnt_q    <= cnt_d;
            rhalf_q  <= rhalf_d;
            if (wr_ok && cfg_q.wr_x9) begin
                whalf_q <= !whalf_q;
                wbyte_q <= lo9;
            end
        end
    end

    // offset registers: defaults at reset, then parallel or serial loads
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            empty_off_q <= `MF_DEF0;
            full_off_q  <= `MF_DEF0;
            lsel_q      <= 1'b0;
        end else if (master_reset) begin
            empty_off_q <= def_off({offset_access_enable_n_i,
                                    offset_default_sel1_i, offset_default_sel0_i});
            full_off_q  <= def_off({offset_access_enable_n_i,
                                    offset_default_sel1_i, offset_default_sel0_i});
            lsel_q      <= 1'b0;
        end else if (pload) begin
            if (lsel_q) full_off_q <= pval;
            else        empty_off_q <= pval;
            lsel_q <= !lsel_q;
        end else if (sload) begin
            // serial chain: full offset first, then empty offset
            {full_off_q, empty_off_q} <= {full_off_q[`MF_OFFW-2:0], empty_off_q,
                                          fall_through_mode_i};
        end
    end

    // output register: fifo data, or offsets when read back
    always_ff @(posedge clock_i) begin
        if (rst_i || master_reset) begin
            data_q <= '0;
            rsel_q <= 1'b0;
        end else if (oread) begin
            data_q <= {1'b0, rsel_q ? full_off_q : empty_off_q};
            rsel_q <= !rsel_q;
        end else if (cfg_q.fall_through_mode || rd_ok) begin
            data_q <= view;
        end
    end

    // flags, all registered from next-state count
    always_ff @(posedge clock_i) begin
        if (rst_i || master_reset) begin
            ef_q  <= 1'b0;
            ff_q  <= 1'b1;
            hf_q  <= 1'b1;
            pae_q <= 1'b0;
            paf_q <= 1'b1;
        end else begin
            ef_q  <= cnt_d != `MF_CW'(0);
            ff_q  <= cnt_d != `MF_DEPTH;
            hf_q  <= !(cnt_d > `MF_HALF);
            pae_q <= !(cnt_d < `MF_CW'(empty_off_q));
            paf_q <= !(free_d <= `MF_CW'(full_off_q));
        end
    end
    assign read_data_o           = data_q;
    assign empty_flag_n_o        = ef_q;
    assign full_indicator_n_o    = ff_q;
    assign half_level_flag_n_o   = hf_q;
    assign almost_empty_flag_n_o = pae_q;
    assign almost_full_flag_n_o  = paf_q;

    // events: refused write, refused read, reaching full, reaching empty
    assign ev = {cnt_d == `MF_CW'(0) && cnt_q != `MF_CW'(0),
                 cnt_d == `MF_DEPTH && cnt_q != `MF_DEPTH,
                 rd_req && !can_rd,
                 wr_req && !can_wr};

    // axi4-lite: write address and data are taken together in one cycle
    logic       awr_q, arr_q, bv_q, rv_q;
    resp_t      bresp_q, rresp_q;
    logic [31:0] rdata_q;
    wire aw_go  = s_axi_awvalid && s_axi_wvalid && !bv_q && !awr_q;
    wire w_fire = awr_q;
    wire w_hit  = s_axi_awaddr == `MF_REG_STATUS || s_axi_awaddr == `MF_REG_MASK;
    wire w1c    = w_fire && s_axi_awaddr == `MF_REG_STATUS && s_axi_wstrb[0];
    wire wmask  = w_fire && s_axi_awaddr == `MF_REG_MASK && s_axi_wstrb[0];
    wire ar_go  = s_axi_arvalid && !rv_q && !arr_q;
    wire [31:0] rmux =
        s_axi_araddr == `MF_REG_STATUS ? 32'(stat_q) :
        s_axi_araddr == `MF_REG_MASK   ? 32'(mask_q) :
        s_axi_araddr == `MF_REG_CONFIG ? 32'(cfg_q)  : 32'(cnt_q);
    wire r_hit  = s_axi_araddr[1:0] == 2'h0;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            awr_q   <= 1'b0;
            arr_q   <= 1'b0;
            bv_q    <= 1'b0;
            rv_q    <= 1'b0;
            bresp_q <= RESP_OKAY;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else begin
            awr_q <= aw_go;
            arr_q <= ar_go;
            if (w_fire) begin
                bv_q    <= 1'b1;
                bresp_q <= w_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bv_q <= 1'b0;
            end
            if (arr_q) begin
                rv_q    <= 1'b1;
                rdata_q <= r_hit ? rmux : 32'h0000_0000;
                rresp_q <= r_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rv_q <= 1'b0;
            end
        end
    end

    // sticky status: a new event wins over a write-one clear in the same cycle
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            stat_q <= '0;
            mask_q <= '0;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~(w1c ? s_axi_wdata[`MF_EVW-1:0] : '0)) | ev;
            if (wmask) mask_q <= s_axi_wdata[`MF_EVW-1:0];
            irq_q  <= |(((stat_q & ~(w1c ? s_axi_wdata[`MF_EVW-1:0] : '0)) | ev)
                        & (wmask ? s_axi_wdata[`MF_EVW-1:0] : mask_q));
        end
    end
    assign irq_o         = irq_q;
    assign s_axi_awready = awr_q;
    assign s_axi_wready  = awr_q;
    assign s_axi_bvalid  = bv_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arr_q;
    assign s_axi_rvalid  = rv_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // checks on the flags, mode latches and offset paths
    sequence s_run;
        !rst_i && master_reset_n_i;
    endsequence
    sequence s_released;
        master_reset ##1 s_run;
    endsequence
    a_empty_map: assert property (@(posedge clock_i) disable iff (rst_i)
        s_run ##1 s_run |-> empty_flag_n_o == ($past(cnt_d) != '0))
        else $error("empty pin disagrees with count");
    a_full_map: assert property (@(posedge clock_i) disable iff (rst_i)
        s_run ##1 s_run |-> full_indicator_n_o == ($past(cnt_d) != `MF_DEPTH))
        else $error("full pin disagrees with count");
    a_half_level: assert property (@(posedge clock_i) disable iff (rst_i)
        s_run ##1 s_run |-> half_level_flag_n_o == !(cnt_q > `MF_HALF))
        else $error("half pin disagrees with count");
    a_almost_empty: assert property (@(posedge clock_i) disable iff (rst_i)
        s_run ##1 s_run |-> almost_empty_flag_n_o == !(cnt_q < `MF_CW'(empty_off_q))
                            || $changed(empty_off_q))
        else $error("almost-empty pin wrong");
    a_mode_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        s_released ##1 s_run |-> $stable(cfg_q))
        else $error("mode latch moved outside master reset");
    a_mode_catch: assert property (@(posedge clock_i) disable iff (rst_i)
        master_reset ##1 !master_reset |-> cfg_q.wr_x9 == $past(write_width_select_i)
                         && cfg_q.little_end == $past(byte_order_select_i))
        else $error("mode not caught at release");
    a_parity_load: assert property (@(posedge clock_i) disable iff (rst_i)
        pload && !lsel_q && cfg_q.ip && !cfg_q.wr_x9 |=>
            empty_off_q == {1'b0, $past(write_data_in_i[16:9]), $past(write_data_in_i[7:0])})
        else $error("interspersed parity load wrong");
    a_data_untouched: assert property (@(posedge clock_i) disable iff (rst_i)
        push && !cfg_q.wr_x9 |-> push_word == write_data_in_i)
        else $error("write data altered");
    a_access_steer: assert property (@(posedge clock_i) disable iff (rst_i)
        acc |-> !push && !pop)
        else $error("fifo moved while offsets accessed");
endmodule // matchfifo

/* File: rtl/matchfifo_defs.svh */
// constants for the bus-matching fifo: geometry, defaults, register map
`ifndef MATCHFIFO_DEFS_SVH
`define MATCHFIFO_DEFS_SVH
`define MF_DEPTH        18'h20000
`define MF_HALF         18'h10000
`define MF_AW           17
`define MF_CW           18
`define MF_OFFW         17
`define MF_DW           18
`define MF_BW           9
// default offsets indexed by {access, sel1, sel0}
`define MF_DEF0         17'h0007F
`define MF_DEF1         17'h003FF
`define MF_DEF2         17'h00FFF
`define MF_DEF3         17'h00007
`define MF_DEF4         17'h0001F
`define MF_DEF5         17'h0003F
`define MF_DEF6         17'h000FF
`define MF_DEF7         17'h001FF
// register byte offsets
`define MF_REG_STATUS   4'h0
`define MF_REG_MASK     4'h4
`define MF_REG_CONFIG   4'h8
`define MF_REG_LEVEL    4'hC
// status and mask bit positions
`define MF_EV_WROVF     0
`define MF_EV_RDUNF     1
`define MF_EV_FULL      2
`define MF_EV_EMPTY     3
`define MF_EVW          4
`define MF_RESP_OKAY    2'h0
`define MF_RESP_SLVERR  2'h2
`endif

/* File: rtl/matchfifo_pkg.sv */
// types shared by the bus-matching fifo files
`include "matchfifo_defs.svh"
package matchfifo_pkg;
    // modes caught at master reset
    typedef struct packed {
        logic       little_end;
        logic       wr_x9;
        logic       rd_x9;
        logic       ip;
        logic       fall_through_mode;
        logic       serial;
        logic [1:0] fsel;
    } cfg_t;
    typedef enum logic [1:0] {
        RESP_OKAY   = `MF_RESP_OKAY,
        RESP_SLVERR = `MF_RESP_SLVERR
    } resp_t;
endpackage

/* File: rtl/matchfifo_store.sv */
// word store of the fifo with write-to-read bypass
`timescale 1ns/1ps
`include "matchfifo_defs.svh"
module matchfifo_store (
    // clock
    input  wire logic                clock_i,
    // write side
    input  wire logic                we_i,
    input  wire logic [`MF_AW-1:0]   waddr_i,
    input  wire logic [`MF_DW-1:0]   wdata_i,
    // read side
    input  wire logic [`MF_AW-1:0]   raddr_i,
    output logic      [`MF_DW-1:0]   rdata_o
);
    logic [`MF_DW-1:0] mem [0:`MF_DEPTH-1];
    // bypass so a word written to the head is visible the same cycle
    assign rdata_o = (we_i && waddr_i == raddr_i) ? wdata_i : mem[raddr_i];
    always_ff @(posedge clock_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end
endmodule // matchfifo_store

/* File: verification/bus_matching_fifo_config_flags_tb_top.sv */
// self-checking bench: latched modes, byte steering, flags, offsets, status bits
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end
module bus_matching_fifo_config_flags_tb_top;
    import matchfifo_pkg::*;
    typedef struct packed {
        cfg_t        cfg;
        logic [17:0] data;
        logic [17:0] exp1;
        logic [17:0] exp2;
    } row_t;
    logic        clock_i = 1'h0;
    logic        rst_i = 1'h1;
    logic        master_reset_n_i = 1'h1;
    logic        ld_n = 1'h1;
    cfg_t        pins = 8'h00;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [17:0] write_data_in_i, read_data_o;
    logic        write_en_n_i, serial_en_n_i, read_en_n_i, serial_bit, irq_o;
    logic        empty_flag_n_o, full_indicator_n_o, half_level_flag_n_o;
    logic        almost_empty_flag_n_o, almost_full_flag_n_o;
    int          failures = 0, checked = 0, cycles = 0;
    logic [8:0]  b0, b1;
    wire  [4:0]  flags = {empty_flag_n_o, full_indicator_n_o, half_level_flag_n_o,
                          almost_empty_flag_n_o, almost_full_flag_n_o};
    // pins {little,wr_x9,rd_x9,ip,fall_through_mode,serial,fsel}, written word, expected reads
    row_t rows [7] = '{
        '{8'h04, 18'h2A5C3, 18'h2A5C3, 18'h00000}, '{8'h35, 18'h2A5C3, 18'h00152, 18'h001C3},
        '{8'hA2, 18'h2A5C3, 18'h001C3, 18'h00152}, '{8'hC7, 18'h2A5C3, 18'h2A5C3, 18'h00000},
        '{8'h50, 18'h2A5C3, 18'h2A5C3, 18'h00000}, '{8'h0D, 18'h2A5C3, 18'h2A5C3, 18'h00000},
        '{8'h66, 18'h2A5C3, 18'h00152, 18'h001C3}};
    // free-running clock and a ceiling far above the few hundred cycles needed
    always #5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end
    // the serial pin carries the timing mode only while master reset is low
    matchfifo i_dut (
        .clock_i, .rst_i, .master_reset_n_i,
        .byte_order_select_i(pins.little_end), .write_width_select_i(pins.wr_x9),
        .read_width_select_i(pins.rd_x9), .parity_placement_select_i(pins.ip),
        .offset_default_sel0_i(pins.fsel[0]), .offset_default_sel1_i(pins.fsel[1]),
        .fall_through_mode_i(master_reset_n_i ? serial_bit : pins.fall_through_mode),
        .offset_access_enable_n_i(ld_n), .write_data_in_i, .write_en_n_i, .serial_en_n_i,
        .read_en_n_i, .read_data_o, .empty_flag_n_o, .full_indicator_n_o,
        .half_level_flag_n_o, .almost_empty_flag_n_o, .almost_full_flag_n_o, .irq_o,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp(), .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp(),
        .s_axi_rvalid, .s_axi_rready);
    port_partner u_partner (
        .clock_i, .wr_x9_i(pins.wr_x9), .write_data_in_o(write_data_in_i),
        .write_en_n_o(write_en_n_i), .serial_en_n_o(serial_en_n_i),
        .serial_bit_o(serial_bit), .read_en_n_o(read_en_n_i));
    task automatic give_verdict();
        if (failures == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic settle();
        @(posedge clock_i);
        #1;
    endtask
    // pins are set with master reset low and then held until the next one
    task automatic mreset(input cfg_t c, input logic l);
        @(posedge clock_i);
        master_reset_n_i <= 1'h0;
        pins <= c;
        ld_n <= c.serial;
        repeat (2) @(posedge clock_i);
        #1;
        `CHK(flags, 5'h0D)
        @(posedge clock_i);
        master_reset_n_i <= 1'h1;
        @(posedge clock_i);
        ld_n <= l;
    endtask
    task automatic read_check(input logic [17:0] e);
        u_partner.pop();
        #1;
        `CHK(pins.rd_x9 ? {9'h000, read_data_o[8:0]} : read_data_o, e)
    endtask
    // address and data offered together, each dropped at its own ready
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        logic aw_done, w_done;
        aw_done = 1'h0;
        w_done = 1'h0;
        @(posedge clock_i);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!(aw_done && w_done)) begin
            @(posedge clock_i);
            if (s_axi_awready === 1'h1) begin
                s_axi_awvalid <= 1'h0;
                aw_done = 1'h1;
            end
            if (s_axi_wready === 1'h1) begin
                s_axi_wvalid <= 1'h0;
                w_done = 1'h1;
            end
        end
        do @(posedge clock_i); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
    endtask
    task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock_i);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge clock_i); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge clock_i); while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        s_axi_rready <= 1'h0;
    endtask
    initial begin
        repeat (3) @(posedge clock_i);
        rst_i <= 1'h0;
        // one word through each of seven width, order, parity and timing mixes
        foreach (rows[k]) begin
            mreset(rows[k].cfg, 1'h1);
            axi_read(4'h8, rd);
            `CHK(rd, {24'h000000, rows[k].cfg})
            b0 = rows[k].cfg.little_end ? rows[k].data[8:0] : rows[k].data[17:9];
            b1 = rows[k].cfg.little_end ? rows[k].data[17:9] : rows[k].data[8:0];
            if (rows[k].cfg.wr_x9) begin
                u_partner.push({9'h000, b0}, 1);
                u_partner.push({9'h000, b1}, 1);
            end else
                u_partner.push(rows[k].data, 1);
            settle();
            `CHK(empty_flag_n_o, 1'h1)
            if (rows[k].cfg.fall_through_mode) begin
                `CHK(read_data_o, rows[k].exp1)
            end else begin
                read_check(rows[k].exp1);
                if (rows[k].cfg.rd_x9)
                    read_check(rows[k].exp2);
                settle();
                `CHK(empty_flag_n_o, 1'h0)
            end
        end
        // default offset 7: almost-empty lifts at the seventh word
        mreset(8'h03, 1'h1);
        u_partner.push(18'h00100, 6);
        settle();
        `CHK(flags, 5'h1D)
        u_partner.push(18'h00100, 1);
        settle();
        `CHK(almost_empty_flag_n_o, 1'h1)
        // parallel load ignores bits 16 and 17 without interspersed parity
        mreset(8'h00, 1'h0);
        u_partner.push(18'h30005, 1);
        u_partner.push(18'h00009, 1);
        read_check(18'h00005);
        read_check(18'h00009);
        @(posedge clock_i);
        ld_n <= 1'h1;
        u_partner.push(18'h00200, 4);
        settle();
        `CHK(almost_empty_flag_n_o, 1'h0)
        u_partner.push(18'h00200, 1);
        settle();
        `CHK(almost_empty_flag_n_o, 1'h1)
        // serial load: full offset in the upper seventeen bits
        mreset(8'h04, 1'h0);
        u_partner.shift({17'h00010, 17'h00003});
        read_check(18'h00003);
        read_check(18'h00010);
        // refused read on empty raises the interrupt until cleared
        @(posedge clock_i);
        ld_n <= 1'h1;
        axi_write(4'h0, 32'h0000000F);
        axi_write(4'h4, 32'h00000002);
        u_partner.pop();
        repeat (2) settle();
        `CHK(irq_o, 1'h1)
        axi_read(4'h0, rd);
        `CHK(rd & 32'h00000002, 32'h00000002)
        axi_write(4'h0, 32'h00000002);
        settle();
        `CHK(irq_o, 1'h0)
        give_verdict();
    end
endmodule // bus_matching_fifo_config_flags_tb_top

/* File: verification/port_partner.sv */
// writer and reader model driving the data, serial and read strobes of the fifo
`timescale 1ns/1ps
module port_partner (
    // clock and write width
    input  wire logic        clock_i,
    input  wire logic        wr_x9_i,
    // strobes and data toward the fifo
    output logic      [17:0] write_data_in_o,
    output logic             write_en_n_o,
    output logic             serial_en_n_o,
    output logic             serial_bit_o,
    output logic             read_en_n_o
);
    // all strobes idle from time zero
    initial begin
        {write_en_n_o, serial_en_n_o, read_en_n_o, serial_bit_o} = 4'hE;
        write_data_in_o = 18'h00000;
    end
    // n back-to-back words; a released bus shows the inverse so stale data never passes
    task automatic push(input logic [17:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock_i);
            write_en_n_o    <= 1'h0;
            write_data_in_o <= wr_x9_i ? {9'h000, d[8:0]} : d + 18'(i);
        end
        @(posedge clock_i);
        write_en_n_o    <= 1'h1;
        write_data_in_o <= wr_x9_i ? {9'h000, ~d[8:0]} : ~d;
    endtask
    // one read strobe, also the offset readback while access is low
    task automatic pop();
        @(posedge clock_i);
        read_en_n_o <= 1'h0;
        @(posedge clock_i);
        read_en_n_o <= 1'h1;
    endtask
    // 34 bits msb first into the offset shifter
    task automatic shift(input logic [33:0] v);
        for (int i = 33; i >= 0; i--) begin
            @(posedge clock_i);
            serial_en_n_o <= 1'h0;
            serial_bit_o  <= v[i];
        end
        @(posedge clock_i);
        serial_en_n_o <= 1'h1;
        serial_bit_o  <= ~v[0];
    endtask
endmodule // port_partner
